// file: timer_defs.svh
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// prescaler ratios of the alternate clock sources
`define TMR_DIV_SYS        4'hc
`define TMR_DIV_EXT        4'h8
`define TMR_DIV_LFO        4'h8
`define TMR_PRESCALE_W     4

// alternate clock source field encodings
`define TMR_SRC_DIV12      2'h0
`define TMR_SRC_EXT8       2'h1
`define TMR_SRC_RSVD       2'h2
`define TMR_SRC_LFO8       2'h3

// count limits and reset values
`define TMR_BYTE_MAX       8'hff
`define TMR_BYTE_RESET     8'h00
`define TMR_WORD_MAX       16'hffff

// timer clocks for which the sync-pending flag stays up after a foreign wake
`define TMR_SYNC_TICKS     2'h3
`define TMR_SYNC_ZERO      2'h0
`define TMR_SYNC_ONE       2'h1

`endif

// file: timer_pkg.sv
package timer_pkg;

    // control bits of the timer, driven by software
    typedef struct packed {
        logic       irq_enable;     // timer interrupt enable
        logic       low_irq_enable; // low byte interrupt enable
        logic       capture_enable; // lfo capture mode
        logic       split_mode;     // two 8-bit timers when set
        logic       run_control;    // run control
        logic [1:0] alt_source;     // shared alternate clock source field
        logic       high_system_clock;    // high byte uses system clock
        logic       low_system_clock;     // low byte uses system clock
    } timer_ctrl_s;

    // software write strobes with their data
    typedef struct packed {
        logic       wr_count_low;
        logic       wr_count_high;
        logic       wr_reload_low;
        logic       wr_reload_high;
        logic       clr_high_flag;
        logic       clr_low_flag;
        logic [7:0] data;
    } timer_write_s;

    // one-cycle ticks produced by the prescalers
    typedef struct packed {
        logic div12;    // system clock / 12
        logic ext8;     // external oscillator / 8
        logic lfo8;     // low-frequency oscillator / 8
        logic lfo_fall; // falling edge of the low-frequency oscillator
    } timer_ticks_s;

endpackage : timer_pkg

// file: timer_prescaler.sv
`timescale 1ns/1ps
`include "timer_defs.svh"

module timer_prescaler (
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_nrst,
    input  wire logic                    i_suspend,
    input  wire logic                    i_ext_osc,
    input  wire logic                    i_lfo,
    output timer_pkg::timer_ticks_s      o_ticks
);
    import timer_pkg::*;

    logic [`TMR_PRESCALE_W-1:0] sys_cnt_reg, sys_cnt_next;   // /12 divider
    logic [`TMR_PRESCALE_W-1:0] ext_cnt_reg, ext_cnt_next;   // /8 on ext edges
    logic [`TMR_PRESCALE_W-1:0] lfo_cnt_reg, lfo_cnt_next;   // /8 on lfo edges
    logic                       ext_prev_reg, lfo_prev_reg;  // edge history
    logic                       ext_tick_reg, ext_tick_next; // resynced tick
    logic                       lfo_tick_reg, lfo_tick_next; // resynced tick
    logic                       div12_reg, div12_next;
    logic                       lfo_fall_reg, lfo_fall_next;
    logic                       ext_rise, lfo_rise;
    logic                       ext_direct, lfo_direct;

    // edge detect and divide; in suspend the raw tick drives the counter
    // sync bypassed in suspend
    always_comb begin
        ext_rise      = i_ext_osc & ~ext_prev_reg;
        lfo_rise      = i_lfo & ~lfo_prev_reg;
        ext_direct    = ext_rise & (ext_cnt_reg == (`TMR_DIV_EXT - 4'h1));
        lfo_direct    = lfo_rise & (lfo_cnt_reg == (`TMR_DIV_LFO - 4'h1));
        sys_cnt_next  = (sys_cnt_reg == (`TMR_DIV_SYS - 4'h1)) ? '0 : sys_cnt_reg + 4'h1;
        ext_cnt_next  = ext_direct ? '0 : (ext_rise ? ext_cnt_reg + 4'h1 : ext_cnt_reg);
        lfo_cnt_next  = lfo_direct ? '0 : (lfo_rise ? lfo_cnt_reg + 4'h1 : lfo_cnt_reg);
        div12_next    = (sys_cnt_reg == (`TMR_DIV_SYS - 4'h1));
        ext_tick_next = ext_direct & ~i_suspend;
        lfo_tick_next = lfo_direct & ~i_suspend;
        lfo_fall_next = ~i_lfo & lfo_prev_reg;
    end

    // register stage
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            sys_cnt_reg  <= '0;
            ext_cnt_reg  <= '0;
            lfo_cnt_reg  <= '0;
            ext_prev_reg <= 1'b0;
            lfo_prev_reg <= 1'b0;
            ext_tick_reg <= 1'b0;
            lfo_tick_reg <= 1'b0;
            div12_reg    <= 1'b0;
            lfo_fall_reg <= 1'b0;
        end else begin
            sys_cnt_reg  <= sys_cnt_next;
            ext_cnt_reg  <= ext_cnt_next;
            lfo_cnt_reg  <= lfo_cnt_next;
            ext_prev_reg <= i_ext_osc;
            lfo_prev_reg <= i_lfo;
            ext_tick_reg <= ext_tick_next;
            lfo_tick_reg <= lfo_tick_next;
            div12_reg    <= div12_next;
            lfo_fall_reg <= lfo_fall_next;
        end
    end

    // three divided clock ticks and the lfo falling edge
    // ext8 and lfo8: direct tick in suspend, resynced tick otherwise
    always_comb begin
        o_ticks.div12    = div12_reg;
        o_ticks.ext8     = i_suspend ? ext_direct : ext_tick_reg;
        o_ticks.lfo8     = i_suspend ? lfo_direct : lfo_tick_reg;
        o_ticks.lfo_fall = lfo_fall_reg;
    end

endmodule : timer_prescaler

// file: auto_reload_timer_lfo_capture.sv
`timescale 1ns/1ps
`include "timer_defs.svh"

// How it works
// - 16-bit counter from two bytes, split selectable
// - four selectable timer clock sources
// - ext and lfo divided clocks synced except in suspend
// - counts in suspend, overflow wakes device
// - sync-pending flag up three clocks after foreign wake
// - 16-bit rollover reloads and sets high flag
// - interrupt on every 16-bit overflow
// - low byte rollover interrupt when enabled
// - split mode: two 8-bit auto-reload counters
// - run bit gates high byte only in split
// - per-byte clock select with shared field
// - split mode flags per byte rollover
// - split interrupts from high, optionally low
// - flags cleared only by software
// - lfo falling edge captures count, sets flag
module auto_reload_timer_lfo_capture (
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_nrst,
    input  wire logic                    i_suspend,      // oscillator in suspend
    input  wire logic                    i_ext_osc,      // external oscillator level
    input  wire logic                    i_lfo,          // low-frequency oscillator level
    input  wire timer_pkg::timer_ctrl_s  i_ctrl,         // control bits
    input  wire timer_pkg::timer_write_s i_wr,           // software writes
    output logic [7:0]                   o_count_low_byte,
    output logic [7:0]                   o_count_high_byte,
    output logic [7:0]                   o_reload_low_byte,
    output logic [7:0]                   o_reload_high_byte,
    output logic                         o_high_overflow_flag,
    output logic                         o_low_overflow_flag,
    output logic                         o_sync_pending_flag,
    output logic                         o_irq_req,      // level interrupt request
    output logic                         o_wake          // one-cycle wake pulse
);
    import timer_pkg::*;

    // all count, flag and suspend state lives here; the prescaler only divides the
    // system clock and slow oscillator levels into one-cycle ticks on i_sys_clk, so every
    // register below runs on every edge and a tick just marks
    // the edges on which a byte may move
    timer_ticks_s ticks;               // prescaler ticks
    logic [1:0]   byte_tick;           // selected tick per byte, 0 low 1 high
    logic [1:0]   byte_system_clock;         // per-byte system clock select

    // byte registers, sticky flags and suspend bookkeeping

    logic [7:0]   cnt_lo_reg, cnt_lo_next;     // count low byte
    logic [7:0]   cnt_hi_reg, cnt_hi_next;     // count high byte
    logic [7:0]   rld_lo_reg, rld_lo_next;     // reload low byte
    logic [7:0]   rld_hi_reg, rld_hi_next;     // reload high byte
    logic         flag_hi_reg, flag_hi_next;   // high overflow flag
    logic         flag_lo_reg, flag_lo_next;   // low overflow flag
    logic [1:0]   sync_cnt_reg, sync_cnt_next; // remaining sync timer clocks
    logic         susp_prev_reg;               // suspend history for exit detect
    logic         timer_woke_reg, timer_woke_next; // wake came from the timer
    logic         wake_reg, wake_next;         // wake pulse
    logic         irq_reg, irq_next;           // registered request

    // scratch terms of the counting logic; recomputed each cycle,
    // never read by a clocked process directly
    logic         lo_ovf;              // low byte rolls over at ff
    logic         hi_ovf;              // high byte (or full word) rolls over
    logic         lo_run;              // low byte counts this cycle
    logic         hi_run;              // high byte counts this cycle
    logic         capture;             // capture event this cycle

    // one shared divider per source, so two bytes on one source
    // tick on the same edge

    timer_prescaler u_prescaler (
        .i_sys_clk (i_sys_clk),
        .i_nrst    (i_nrst),
        .i_suspend (i_suspend),
        .i_ext_osc (i_ext_osc),
        .i_lfo     (i_lfo),
        .o_ticks   (ticks)
    );

    // index 0 is the low byte, index 1 the high byte
    assign byte_system_clock = {i_ctrl.high_system_clock, i_ctrl.low_system_clock};

    // per-byte clock select; reserved code never ticks
    // the per-byte system clock select wins over the shared field
    genvar b;
    generate
        for (b = 0; b < 2; b++) begin : g_clk_sel
            always_comb begin
                // system clock: a tick on every edge
                if (byte_system_clock[b]) begin
                    byte_tick[b] = 1'b1;
                end else begin
                    // shared field picks the slow source; the reserved
                    // code gives no tick, so the byte holds its value
                    case (i_ctrl.alt_source)
                        `TMR_SRC_DIV12: byte_tick[b] = ticks.div12;
                        `TMR_SRC_EXT8:  byte_tick[b] = ticks.ext8;
                        `TMR_SRC_LFO8:  byte_tick[b] = ticks.lfo8;
                        default:        byte_tick[b] = 1'b0;
                    endcase
                end
            end
        end
    endgenerate

    // counter, reload, flag and wake logic
    always_comb begin
        cnt_lo_next     = cnt_lo_reg;
        cnt_hi_next     = cnt_hi_reg;
        rld_lo_next     = rld_lo_reg;
        rld_hi_next     = rld_hi_reg;
        flag_hi_next    = flag_hi_reg;
        flag_lo_next    = flag_lo_reg;
        lo_ovf          = 1'b0;
        hi_ovf          = 1'b0;
        // capture is meant for 16-bit mode; in split mode it still
        // copies both bytes and sets the high flag
        capture         = i_ctrl.capture_enable & ticks.lfo_fall;

        // the run terms say which byte may move on this edge; the
        // word is one counter, so both halves share the low enable
        // run bit gates only high in split
        if (i_ctrl.split_mode) begin
            lo_run = byte_tick[0];
            hi_run = byte_tick[1] & i_ctrl.run_control;
        end else begin
            // 16-bit mode follows the low byte's clock
            lo_run = byte_tick[0] & i_ctrl.run_control;
            hi_run = lo_run;
        end

        if (i_ctrl.split_mode) begin
            // two independent 8-bit reloads
            // each byte wraps to its own reload value, and the low
            // byte never carries into the high byte here
            if (lo_run) begin
                if (cnt_lo_reg == `TMR_BYTE_MAX) begin
                    lo_ovf      = 1'b1;
                    cnt_lo_next = rld_lo_reg;
                end else begin
                    cnt_lo_next = cnt_lo_reg + 8'h01;
                end
            end
            // the high byte only moves while run control is set
            if (hi_run) begin
                if (cnt_hi_reg == `TMR_BYTE_MAX) begin
                    hi_ovf      = 1'b1;
                    cnt_hi_next = rld_hi_reg;
                end else begin
                    cnt_hi_next = cnt_hi_reg + 8'h01;
                end
            end
        end else if (lo_run) begin
            // low and high form one word
            // the low flag follows every low wrap here too; only
            // the full word wrap reloads
            lo_ovf = (cnt_lo_reg == `TMR_BYTE_MAX);
            if ({cnt_hi_reg, cnt_lo_reg} == `TMR_WORD_MAX) begin
                // word rollover reloads pair
                // the pair is taken as it stands before this edge
                hi_ovf      = 1'b1;
                cnt_lo_next = rld_lo_reg;
                cnt_hi_next = rld_hi_reg;
            end else begin
                // plain increment, the carry runs into the high byte
                {cnt_hi_next, cnt_lo_next} = {cnt_hi_reg, cnt_lo_reg} + 16'h0001;
            end
        end

        // a reload write in the same cycle is applied later in this
        // process and so wins over the capture

        if (capture) begin
            rld_lo_next = cnt_lo_reg;
            rld_hi_next = cnt_hi_reg;
        end

        // writes come after counting on purpose: a write on the
        // edge of a tick replaces the count, the tick is lost
        // software writes replace immediately
        if (i_wr.wr_count_low) begin
            cnt_lo_next = i_wr.data;
        end
        if (i_wr.wr_count_high) begin
            cnt_hi_next = i_wr.data;
        end
        if (i_wr.wr_reload_low) begin
            rld_lo_next = i_wr.data;
        end
        if (i_wr.wr_reload_high) begin
            rld_hi_next = i_wr.data;
        end

        // clears go first and sets after, so an event meeting a
        // clear in one cycle leaves the flag set
        // only software clears, set wins
        if (i_wr.clr_high_flag) begin
            flag_hi_next = 1'b0;
        end
        if (i_wr.clr_low_flag) begin
            flag_lo_next = 1'b0;
        end
        if (hi_ovf || capture) begin
            flag_hi_next = 1'b1;
        end
        if (lo_ovf) begin
            flag_lo_next = 1'b1;
        end

        // wake pulse and wake-source memory both follow the word
        // wrap in 16-bit mode or the high wrap in split mode;
        // the memory is dropped as soon as suspend ends

        wake_next       = i_suspend & hi_ovf;
        timer_woke_next = i_suspend ? (timer_woke_reg | hi_ovf) : 1'b0;

        // built from the next flag values so it rises on the flag's
        // own edge; a software clear drops it at once

        irq_next = i_ctrl.irq_enable &
                   (flag_hi_next | (i_ctrl.low_irq_enable & flag_lo_next));
    end

    // reloaded only when suspend ends with no timer wrap in it;
    // counting starts the cycle after the exit
    // limitation: with the reserved source the low byte never
    // ticks and the pending flag stays up until the source changes

    // sync-pending countdown; counts timer clocks of the low byte source
    // guard after foreign wake
    always_comb begin
        sync_cnt_next = sync_cnt_reg;
        // one step down per low byte tick until zero
        if (sync_cnt_reg != `TMR_SYNC_ZERO && byte_tick[0]) begin
            sync_cnt_next = sync_cnt_reg - `TMR_SYNC_ONE;
        end
        // a second foreign wake while counting starts over
        // new exit wins over the countdown
        if (susp_prev_reg && !i_suspend && !timer_woke_reg) begin
            sync_cnt_next = `TMR_SYNC_TICKS;
        end
    end

    // one register stage for all state; reset is synchronous, so
    // each register loads its next value or a reset constant

    // state registers
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            // bytes and flags clear, nothing pending
            cnt_lo_reg     <= `TMR_BYTE_RESET;
            cnt_hi_reg     <= `TMR_BYTE_RESET;
            rld_lo_reg     <= `TMR_BYTE_RESET;
            rld_hi_reg     <= `TMR_BYTE_RESET;
            flag_hi_reg    <= 1'b0;
            flag_lo_reg    <= 1'b0;
            sync_cnt_reg   <= `TMR_SYNC_ZERO;
            susp_prev_reg  <= 1'b0;
            timer_woke_reg <= 1'b0;
            wake_reg       <= 1'b0;
            irq_reg        <= 1'b0;
        end else begin
            // normal operation loads every next value
            cnt_lo_reg     <= cnt_lo_next;
            cnt_hi_reg     <= cnt_hi_next;
            rld_lo_reg     <= rld_lo_next;
            rld_hi_reg     <= rld_hi_next;
            flag_hi_reg    <= flag_hi_next;
            flag_lo_reg    <= flag_lo_next;
            sync_cnt_reg   <= sync_cnt_next;
            susp_prev_reg  <= i_suspend;
            timer_woke_reg <= timer_woke_next;
            wake_reg       <= wake_next;
            irq_reg        <= irq_next;
        end
    end

    // the pending flag is a compare on a register, so it stays
    // free of glitches from the tick selection

    // all outputs straight from flip-flops except the pending flag, a compare on sync_cnt_reg
    assign o_count_low_byte     = cnt_lo_reg;
    assign o_count_high_byte    = cnt_hi_reg;
    assign o_reload_low_byte    = rld_lo_reg;
    assign o_reload_high_byte   = rld_hi_reg;
    assign o_high_overflow_flag = flag_hi_reg;
    assign o_low_overflow_flag  = flag_lo_reg;
    assign o_sync_pending_flag  = (sync_cnt_reg != `TMR_SYNC_ZERO);
    assign o_irq_req            = irq_reg;
    assign o_wake               = wake_reg;

endmodule : auto_reload_timer_lfo_capture

// file: timer_props.sv
`timescale 1ns/1ps
module timer_props (
    input wire logic                   i_sys_clk,
    input wire logic                   i_nrst,
    input wire timer_pkg::timer_ctrl_s  i_ctrl,
    input wire timer_pkg::timer_write_s i_wr,
    input wire logic [7:0]             o_count_low_byte,
    input wire logic [7:0]             o_count_high_byte,
    input wire logic [7:0]             o_reload_low_byte,
    input wire logic [7:0]             o_reload_high_byte,
    input wire logic                   o_high_overflow_flag,
    input wire logic                   o_low_overflow_flag,
    input wire logic                   o_irq_req,
    input wire logic                   o_wake
);
    import timer_pkg::*;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    logic [15:0] word; // both count bytes as one value
    assign word = {o_count_high_byte, o_count_low_byte};
    // at the top with no count or reload write and no capture, so the load is clean
    sequence word_top_s;
        !i_ctrl.split_mode && !i_ctrl.capture_enable && word == 16'hffff && i_wr[13:10] == 4'h0;
    endsequence
    sequence low_top_s;
        i_ctrl.split_mode && !i_ctrl.capture_enable && o_count_low_byte == 8'hff
            && i_wr[13:10] == 4'h0;
    endsequence
    wrap_word_a: assert property (word_top_s ##1 word != 16'hffff |->
        word == $past({o_reload_high_byte, o_reload_low_byte}) && o_high_overflow_flag)
        else $error("word rollover did not reload");
    wrap_low_a: assert property (low_top_s ##1 o_count_low_byte != 8'hff |->
        o_count_low_byte == $past(o_reload_low_byte) && o_low_overflow_flag)
        else $error("low byte rollover did not reload");
    high_hold_a: assert property (i_ctrl.split_mode && !i_ctrl.run_control
        && !i_wr.wr_count_high |=> $stable(o_count_high_byte))
        else $error("high byte moved while stopped");
    step_low_a: assert property (i_ctrl.split_mode && o_count_low_byte != 8'hff
        && !i_wr.wr_count_low ##1 $changed(o_count_low_byte)
        |-> o_count_low_byte == $past(o_count_low_byte) + 8'h01)
        else $error("low byte step not one");
    wr_low_a: assert property (i_wr.wr_count_low |=> o_count_low_byte == $past(i_wr.data))
        else $error("count write lost");
    wr_rld_a: assert property (i_wr.wr_reload_high |=>
        o_reload_high_byte == $past(i_wr.data))
        else $error("reload write lost");
    high_keep_a: assert property ($fell(o_high_overflow_flag) |-> $past(i_wr.clr_high_flag))
        else $error("high flag cleared by itself");
    low_keep_a: assert property ($fell(o_low_overflow_flag) |-> $past(i_wr.clr_low_flag))
        else $error("low flag cleared by itself");
    irq_level_a: assert property (o_irq_req == ($past(i_ctrl.irq_enable)
        && (o_high_overflow_flag || $past(i_ctrl.low_irq_enable) && o_low_overflow_flag)))
        else $error("interrupt request wrong");
    wake_pulse_a: assert property (o_wake |-> o_high_overflow_flag ##1 !o_wake)
        else $error("wake not a single pulse");
endmodule : timer_props

bind auto_reload_timer_lfo_capture timer_props props (.i_sys_clk, .i_nrst, .i_ctrl, .i_wr,
    .o_count_low_byte, .o_count_high_byte, .o_reload_low_byte, .o_reload_high_byte,
    .o_high_overflow_flag, .o_low_overflow_flag, .o_irq_req, .o_wake);

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
    import timer_pkg::*;
    logic         i_sys_clk = 1'b0;
    logic         i_nrst    = 1'b0;
    logic         i_suspend = 1'b0;
    logic [1:0]   osc_cnt   = 2'h0; // both slow oscillators run at clock / 4
    timer_ctrl_s  ctrl      = '0;
    timer_write_s wr        = '0;
    logic [7:0]   cnt_lo, cnt_hi, rld_lo, rld_hi;
    logic         flag_hi, flag_lo, sync_flag, irq, wake;
    int           err_total = 0;
    int           compares  = 0;
    logic [7:0]   a, b, v;
    auto_reload_timer_lfo_capture dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
        .i_suspend(i_suspend), .i_ext_osc(osc_cnt[1]), .i_lfo(osc_cnt[1]), .i_ctrl(ctrl),
        .i_wr(wr), .o_count_low_byte(cnt_lo), .o_count_high_byte(cnt_hi),
        .o_reload_low_byte(rld_lo), .o_reload_high_byte(rld_hi), .o_high_overflow_flag(flag_hi),
        .o_low_overflow_flag(flag_lo), .o_sync_pending_flag(sync_flag), .o_irq_req(irq),
        .o_wake(wake));
    // 25 ns period
    always #12.5 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        osc_cnt <= osc_cnt + 2'h1;
    end
    task automatic report_and_stop;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // k rising edges, then settle at the falling edge
    task automatic cyc(input int k);
        repeat (k) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
    endtask : cyc
    // one strobe: 5 count low, 4 count high, 3 reload low, 2 reload high, 1/0 clear flags
    task automatic put(input int sel, input logic [7:0] d);
        timer_write_s w;
        w = '0;
        w.data = d;
        w[8+sel] = 1'b1;
        @(posedge i_sys_clk);
        wr <= w;
        @(posedge i_sys_clk);
        wr <= '0;
    endtask : put
    task automatic setc(input timer_ctrl_s c);
        @(posedge i_sys_clk);
        ctrl <= c;
    endtask : setc
    function automatic logic pick(input int w);
        return (w == 0) ? flag_hi : (w == 1) ? flag_lo : wake;
    endfunction : pick
    // bounded wait: 0 high flag, 1 low flag, 2 wake
    task automatic wait_hi(input int w, input int lim);
        int n;
        n = 0;
        // first look only once the last edge's outputs have settled
        @(negedge i_sys_clk);
        while (pick(w) !== 1'b1) begin
            if (n == lim) begin
                err_total++;
                report_and_stop();
            end
            n++;
            cyc(1);
        end
    endtask : wait_hi
    // ticks seen in a 960-cycle window for a source choice
    function automatic logic [7:0] ticks(input logic [1:0] s, input logic sys);
        if (sys) return 8'(960);
        case (s)
            2'h0: return 8'(960 / 12);
            2'h2: return 8'h00;
            default: return 8'(960 / 32);
        endcase
    endfunction : ticks
    initial begin
        a = $urandom(19504);
        repeat (2) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        cyc(1);
        chk({cnt_hi, cnt_lo}, 16'h0000);
        chk({rld_hi, rld_lo}, 16'h0000);
        chk({flag_hi, flag_lo, sync_flag, irq, wake}, 16'h0000);
        // 16-bit, stopped while loading, then run from system clock
        setc(9'h101);
        a = $urandom;
        b = $urandom & 8'h7f;
        put(3, a);
        put(2, b);
        put(5, 8'hfe);
        put(4, 8'hff);
        setc(9'h111);
        wait_hi(0, 10);
        chk({cnt_hi, cnt_lo}, {b, a});
        chk({flag_lo, irq}, 16'h0003);
        cyc(20);
        chk(flag_hi, 1'b1);
        put(1, 8'h00);
        put(0, 8'h00);
        cyc(0);
        chk({flag_hi, flag_lo, irq}, 16'h0000);
        wait_hi(1, 300);
        chk(irq, 1'b0);
        setc(9'h191);
        cyc(2);
        chk(irq, 1'b1);
        // split mode, high byte stopped
        setc(9'h123);
        put(1, 8'h00);
        put(0, 8'h00);
        v = $urandom;
        put(4, v);
        cyc(40);
        chk(cnt_hi, v);
        wait_hi(1, 300);
        chk({cnt_lo, flag_hi, irq}, {a, 2'h0});
        put(4, 8'hfe);
        setc(9'h133);
        wait_hi(0, 10);
        chk({cnt_hi, irq}, {b, 1'b1});
        // every source, high byte on system clock in the reserved case;
        // a zero reload keeps the wrapping high byte a plain count
        put(2, 8'h00);
        // lfo level fed from osc_cnt[1], clock / 4, like ext
        for (int s = 0; s < 4; s++) begin
            setc({5'h03, 2'(s), s == 2, 1'b0});
            put(5, 8'h00);
            put(4, 8'h00);
            cyc(40);
            a = cnt_lo;
            v = cnt_hi;
            cyc(960);
            chk(8'(cnt_lo - a), ticks(2'(s), 1'b0));
            chk(8'(cnt_hi - v), ticks(2'(s), s == 2));
        end
        // suspend with the external source, timer wakes the device
        setc(9'h114);
        put(1, 8'h00);
        put(0, 8'h00);
        put(5, 8'hfd);
        put(4, 8'hff);
        @(posedge i_sys_clk);
        i_suspend <= 1'b1;
        wait_hi(2, 300);
        chk(flag_hi, 1'b1);
        @(posedge i_sys_clk);
        i_suspend <= 1'b0;
        cyc(2);
        chk(sync_flag, 1'b0);
        // foreign wake: sync flag up for three system clock ticks
        setc(9'h111);
        put(4, 8'h00);
        @(posedge i_sys_clk);
        i_suspend <= 1'b1;
        cyc(5);
        @(posedge i_sys_clk);
        i_suspend <= 1'b0;
        cyc(1);
        chk(sync_flag, 1'b1);
        cyc(2);
        chk(sync_flag, 1'b1);
        cyc(1);
        chk(sync_flag, 1'b0);
        // capture of a frozen count on the slow oscillator's fall
        // capture in 16-bit mode with run control off
        setc(9'h141);
        a = $urandom;
        v = $urandom;
        put(5, a);
        put(4, v);
        put(1, 8'h00);
        cyc(0);
        wait_hi(0, 20);
        chk({rld_hi, rld_lo}, {v, a});
        chk(irq, 1'b1);
        report_and_stop();
    end
endmodule : testbench
